// >>> verilog/mmb_pkg.sv
// Shared constants and types for the two-wire data buffer block
package mmb_pkg;

  typedef logic [7:0]  mmb_addr_t;
  typedef logic [31:0] mmb_word_t;
  typedef logic [1:0]  mmb_resp_t;

  // Register byte addresses
  localparam mmb_addr_t OFS_CTRL = 8'h00;
  localparam mmb_addr_t OFS_ADDR = 8'h04;
  localparam mmb_addr_t OFS_STAT = 8'h08;
  localparam mmb_addr_t OFS_TXD  = 8'h0C;
  localparam mmb_addr_t OFS_RXD  = 8'h10;

  // Control register fields
  localparam int CTRL_EN    = 7;
  localparam int CTRL_MST   = 4;
  localparam int CTRL_MDIR  = 3;
  localparam int CTRL_NOACK = 0;

  // Status register fields
  localparam int STAT_ALIF  = 9;
  localparam int STAT_NAKIF = 8;
  localparam int STAT_RXIF  = 7;
  localparam int STAT_TXIF  = 6;
  localparam int STAT_MATCH = 5;
  localparam int STAT_SRW   = 4;
  localparam int STAT_RXAK  = 3;
  localparam int STAT_BUSY  = 2;
  localparam int STAT_TXBE  = 1;
  localparam int STAT_RXBF  = 0;

  // Reset values
  localparam logic [7:0] RST_TXD = 8'hFF;
  localparam logic [6:0] RST_OWN = 7'h50;

  localparam mmb_resp_t RESP_OKAY   = 2'b00;
  localparam mmb_resp_t RESP_SLVERR = 2'b10;

  // Bit engine counts
  localparam logic [3:0] BITS_DATA = 4'h8;
  localparam logic [3:0] STOP_LAST = 4'h3;

  // Master clock half period
  localparam int CLK_NS      = 50;
  localparam int BUS_HALF_NS = 5000;
  localparam logic [7:0] HALF_CYC = 8'(BUS_HALF_NS / CLK_NS);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_BYTE  = 4'b0100,
    ST_STOP  = 4'b1000
  } mmb_state_t;

endpackage : mmb_pkg

// >>> verilog/mmb_line_if.sv
// Synchronised line levels and bus events passed to the bit engine
interface mmb_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic busy;
  logic enable;

  modport mon (output scl, sda, scl_rise, scl_fall, start, stop, busy,
               input enable);
  modport eng (input scl, sda, scl_rise, scl_fall, start, stop, busy,
               output enable);
endinterface : mmb_line_if

// >>> verilog/mmb_line_mon.sv
// Line synchroniser, edge and start/stop detector, bus-busy tracker
module mmb_line_mon (
  input wire logic   clk,
  input wire logic   rst,
  input wire logic   scl_pin,
  input wire logic   sda_pin,
  mmb_line_if.mon    lnk
);
  import mmb_pkg::*;

  typedef struct packed {
    logic scl1;
    logic sda1;
    logic scl2;
    logic sda2;
    logic scl3;
    logic sda3;
    logic busy;
  } mmb_mon_t;

  mmb_mon_t q;
  mmb_mon_t n;

  // Stage 1 feeds stage 2 only; edges compare stages 2 and 3
  always_comb begin
    n      = q;
    n.scl1 = scl_pin;
    n.sda1 = sda_pin;
    n.scl2 = q.scl1;
    n.sda2 = q.sda1;
    n.scl3 = q.scl2;
    n.sda3 = q.sda2;
    if (!lnk.enable) begin
      n.busy = 1'b0;
    end else if (lnk.start) begin
      n.busy = 1'b1;
    end else if (lnk.stop) begin
      n.busy = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '{default: 1'b1, busy: 1'b0};
    end else begin
      q <= n;
    end
  end

  assign lnk.scl      = q.scl2;
  assign lnk.sda      = q.sda2;
  assign lnk.scl_rise = q.scl2 & ~q.scl3;
  assign lnk.scl_fall = ~q.scl2 & q.scl3;
  assign lnk.start    = q.scl2 & q.scl3 & q.sda3 & ~q.sda2;
  assign lnk.stop     = q.scl2 & q.scl3 & ~q.sda3 & q.sda2;
  assign lnk.busy     = q.busy;

endmodule : mmb_line_mon

// >>> verilog/mmb_top.sv
// Two-wire serial unit data buffers with AXI4-Lite register access
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
module mmb_top (
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  input  wire mmb_pkg::mmb_addr_t AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire mmb_pkg::mmb_word_t WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output mmb_pkg::mmb_resp_t     BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire mmb_pkg::mmb_addr_t ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output mmb_pkg::mmb_word_t     RDATA,
  output mmb_pkg::mmb_resp_t     RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  input  wire logic              SCL_IN,
  output logic                   SCL_OUT,
  output logic                   SCL_OE,
  input  wire logic              SDA_IN,
  output logic                   SDA_OUT,
  output logic                   SDA_OE
);
  import mmb_pkg::*;

  typedef struct packed {
    logic       aw_ok;
    mmb_addr_t  aw_addr;
    logic       w_ok;
    logic [9:0] w_data;
    logic       w_lane;
    logic       w_lane1;
    logic       bvalid;
    mmb_resp_t  bresp;
    logic       rvalid;
    mmb_word_t  rdata;
    mmb_resp_t  rresp;
    logic       enable;
    logic       mstart;
    logic       mdir;
    logic       nack_dis;
    logic [6:0] own;
    logic [7:0] tx_buf;
    logic [7:0] rx_buf;
    logic       rxif;
    logic       txif;
    logic       match;
    logic       srw;
    logic       rxak;
    logic       txbe;
    logic       rxbf;
    logic       alif;
    logic       nakif;
    mmb_state_t state;
    logic       master;
    logic [7:0] sh;
    logic [3:0] bitcnt;
    logic       is_addr;
    logic       xmit;
    logic       sda_oe;
    logic       scl_oe;
    logic [7:0] hcnt;
  } mmb_core_t;

  mmb_core_t  q;
  mmb_core_t  n;
  mmb_line_if lnk ();
  logic       do_tx;
  logic       do_rx;
  logic       wr_go;

  mmb_line_mon u_mon (
    .clk     (REF_CLK),
    .rst     (RST),
    .scl_pin (SCL_IN),
    .sda_pin (SDA_IN),
    .lnk     (lnk.mon)
  );

  function automatic logic [9:0] stat_word(input mmb_core_t s,
                                           input logic busy);
    logic [9:0] v;
    v             = '0;
    v[STAT_ALIF]  = s.alif;
    v[STAT_NAKIF] = s.nakif;
    v[STAT_RXIF]  = s.rxif;
    v[STAT_TXIF]  = s.txif;
    v[STAT_MATCH] = s.match;
    v[STAT_SRW]   = s.srw;
    v[STAT_RXAK]  = s.rxak;
    v[STAT_BUSY]  = busy;
    v[STAT_TXBE]  = s.txbe;
    v[STAT_RXBF]  = s.rxbf;
    return v;
  endfunction : stat_word

  assign AWREADY    = ~q.aw_ok & ~q.bvalid;
  assign WREADY     = ~q.w_ok & ~q.bvalid;
  assign ARREADY    = ~q.rvalid;
  assign wr_go      = q.aw_ok & q.w_ok & ~q.bvalid;
  assign lnk.enable = q.enable;

  always_comb begin
    n     = q;
    do_tx = 1'b0;
    do_rx = 1'b0;
    // Write address and data are taken independently
    if (AWVALID && AWREADY) begin
      n.aw_ok   = 1'b1;
      n.aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      n.w_ok   = 1'b1;
      n.w_data  = WDATA[9:0];
      n.w_lane  = WSTRB[0];
      n.w_lane1 = WSTRB[1];
    end
    if (q.bvalid && BREADY) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.aw_ok  = 1'b0;
      n.w_ok   = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = RESP_OKAY;
      unique case (q.aw_addr)
        OFS_CTRL: begin
          if (q.w_lane) begin
            n.enable   = q.w_data[CTRL_EN];
            n.mdir     = q.w_data[CTRL_MDIR];
            n.nack_dis = q.w_data[CTRL_NOACK];
            n.mstart   = q.w_data[CTRL_MST];
            // Start request while the bus is taken is a lost arbitration
            if (q.w_data[CTRL_MST] && !q.mstart && lnk.busy) begin
              n.mstart = 1'b0;
              n.alif   = 1'b1;
            end
          end
        end
        OFS_ADDR: begin
          if (q.w_lane) begin
            n.own = q.w_data[7:1];
          end
        end
        OFS_STAT: begin
          // Flags clear by writing zero; engine sets below still win
          if (q.w_lane) begin
            n.rxif = q.rxif & q.w_data[STAT_RXIF];
            n.txif = q.txif & q.w_data[STAT_TXIF];
          end
          if (q.w_lane1) begin
            n.alif  = q.alif & q.w_data[STAT_ALIF];
            n.nakif = q.nakif & q.w_data[STAT_NAKIF];
          end
        end
        OFS_TXD: begin
          if (q.w_lane) begin
            n.tx_buf = q.w_data[7:0];
            n.txbe   = 1'b0;
          end
        end
        OFS_RXD: begin
          n.bresp = RESP_OKAY;
        end
        default: begin
          n.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.rvalid && RREADY) begin
      n.rvalid = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      n.rdata  = '0;
      unique case (ARADDR)
        OFS_CTRL: begin
          n.rdata[CTRL_EN]    = q.enable;
          n.rdata[CTRL_MST]   = q.mstart;
          n.rdata[CTRL_MDIR]  = q.mdir;
          n.rdata[CTRL_NOACK] = q.nack_dis;
        end
        OFS_ADDR: n.rdata[7:0] = {q.own, 1'b0};
        OFS_STAT: n.rdata[9:0] = stat_word(q, lnk.busy);
        OFS_TXD:  n.rdata[7:0] = q.tx_buf;
        OFS_RXD: begin
          n.rdata[7:0] = q.rx_buf;
          n.rxbf       = 1'b0;
        end
        default: n.rresp = RESP_SLVERR;
      endcase
    end

    if (!q.enable) begin
      n.state  = ST_IDLE;
      n.master = 1'b0;
      n.mstart = 1'b0;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
      n.rxif   = 1'b0;
      n.txif   = 1'b0;
      n.bitcnt = '0;
      n.hcnt   = '0;
    end else begin
      unique case (q.state)
        ST_IDLE: begin
          if (q.mstart && !lnk.busy) begin
            n.state  = ST_START;
            n.master = 1'b1;
            n.sda_oe = 1'b1;
            n.hcnt   = '0;
          end else if (lnk.start) begin
            n.state   = ST_BYTE;
            n.is_addr = 1'b1;
            n.xmit    = 1'b0;
            n.bitcnt  = '0;
          end
        end
        ST_START: begin
          n.hcnt = q.hcnt + 8'h01;
          if (q.hcnt == HALF_CYC - 8'h01) begin
            n.hcnt    = '0;
            n.scl_oe  = 1'b1;
            n.state   = ST_BYTE;
            n.sh      = {q.own, q.mdir};
            n.is_addr = 1'b1;
            n.xmit    = 1'b1;
            n.bitcnt  = '0;
          end
        end
        ST_BYTE: begin
          if (q.master) begin
            n.hcnt = q.hcnt + 8'h01;
            if (q.hcnt == HALF_CYC - 8'h01) begin
              n.hcnt   = '0;
              n.scl_oe = ~q.scl_oe;
            end
          end
          if (lnk.scl_fall) begin
            if (q.bitcnt == BITS_DATA) begin
              n.sda_oe = 1'b0;
              if (q.is_addr && !q.master) begin
                if (q.sh[7:1] != q.own) begin
                  n.state = ST_IDLE;
                end else begin
                  n.match  = 1'b1;
                  n.srw    = q.sh[0];
                  n.xmit   = q.sh[0];
                  n.sda_oe = 1'b1;
                  do_rx    = 1'b1;
                  do_tx    = q.sh[0];
                end
              end else if (!q.xmit) begin
                do_rx    = 1'b1;
                n.match  = 1'b0;
                n.sda_oe = ~q.nack_dis;
              end
            end else begin
              // drive MSB first on low clock
              n.sda_oe = q.xmit & ~q.sh[7];
            end
          end
          if (lnk.scl_rise) begin
            if (q.bitcnt != BITS_DATA) begin
              if (q.master && q.xmit && !q.sda_oe && !lnk.sda) begin
                n.scl_oe = 1'b0;
                n.sda_oe = 1'b0;
                n.master = 1'b0;
                n.mstart = 1'b0;
                n.alif   = 1'b1;
                // busy left to the line monitor
                n.state  = ST_IDLE;
              end else begin
                n.sh     = {q.sh[6:0], lnk.sda};
                n.bitcnt = q.bitcnt + 4'h1;
              end
            end else begin
              n.bitcnt  = '0;
              n.is_addr = 1'b0;
              if (q.xmit && !(q.is_addr && !q.master)) begin
                n.rxak = lnk.sda;
                if (!lnk.sda) begin
                  if (!q.master || !q.is_addr || !q.mdir) begin
                    do_tx = 1'b1;
                  end else begin
                    n.xmit = 1'b0;
                  end
                end else if (q.master) begin
                  n.nakif  = 1'b1;
                  n.mstart = 1'b0;
                end else begin
                  n.state = ST_IDLE;
                end
              end
              if (q.master && !n.mstart) begin
                n.state  = ST_STOP;
                n.hcnt   = '0;
                n.bitcnt = '0;
              end
            end
          end
          // Repeated start or stop from another master
          if (!q.master && lnk.stop) begin
            n.state  = ST_IDLE;
            n.sda_oe = 1'b0;
          end else if (!q.master && lnk.start) begin
            n.is_addr = 1'b1;
            n.xmit    = 1'b0;
            n.bitcnt  = '0;
            n.sda_oe  = 1'b0;
          end
        end
        ST_STOP: begin
          n.hcnt = q.hcnt + 8'h01;
          if (q.hcnt == HALF_CYC - 8'h01) begin
            n.hcnt   = '0;
            n.bitcnt = q.bitcnt + 4'h1;
            unique case (q.bitcnt)
              4'h0: n.scl_oe = 1'b1;
              4'h1: n.sda_oe = 1'b1;
              4'h2: n.scl_oe = 1'b0;
              default: begin
                n.sda_oe = 1'b0;
                n.master = 1'b0;
                n.state  = ST_IDLE;
              end
            endcase
            if (q.bitcnt > STOP_LAST) begin
              n.state = ST_IDLE;
            end
          end
        end
        default: n.state = ST_IDLE;
      endcase
    end

    if (do_rx && !n.rxbf) begin
      n.rx_buf = q.sh;
      n.rxbf   = 1'b1;
      n.rxif   = 1'b1;
    end
    if (do_tx) begin
      n.sh   = n.tx_buf;
      n.txbe = 1'b1;
      n.txif = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      q <= '{default: '0, state: ST_IDLE, own: RST_OWN,
             tx_buf: RST_TXD, rxak: 1'b1, txbe: 1'b1};
    end else begin
      q <= n;
    end
  end

  assign BVALID  = q.bvalid;
  assign BRESP   = q.bresp;
  assign RVALID  = q.rvalid;
  assign RDATA   = q.rdata;
  assign RRESP   = q.rresp;
  // Open drain: output level is always low, enable pulls
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SCL_OE  = q.scl_oe;
  assign SDA_OE  = q.sda_oe;

endmodule : mmb_top

// >>> verification/mmb_props.sv
// Bus handshake and line release checks for the buffer block top
module mmb_chk (
  input wire logic               REF_CLK,
  input wire logic               RST,
  input wire mmb_pkg::mmb_addr_t AWADDR,
  input wire logic               AWVALID,
  input wire logic               AWREADY,
  input wire mmb_pkg::mmb_word_t WDATA,
  input wire logic [3:0]         WSTRB,
  input wire logic               WVALID,
  input wire logic               WREADY,
  input wire mmb_pkg::mmb_resp_t BRESP,
  input wire logic               BVALID,
  input wire logic               BREADY,
  input wire mmb_pkg::mmb_addr_t ARADDR,
  input wire logic               ARVALID,
  input wire logic               ARREADY,
  input wire mmb_pkg::mmb_word_t RDATA,
  input wire mmb_pkg::mmb_resp_t RRESP,
  input wire logic               RVALID,
  input wire logic               RREADY,
  input wire logic               SCL_OUT,
  input wire logic               SCL_OE,
  input wire logic               SDA_OUT,
  input wire logic               SDA_OE
);
  import mmb_pkg::*;
  logic wr_both;
  logic en_ff;
  logic nxt_en;
  assign wr_both = AWVALID && AWREADY && WVALID && WREADY;
  // Shadow of the enable bit; leads the real one by one cycle
  always_comb begin
    nxt_en = en_ff;
    if (wr_both && AWADDR == OFS_CTRL && WSTRB[0])
      nxt_en = WDATA[CTRL_EN];
  end
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST)
      en_ff <= 1'b0;
    else
      en_ff <= nxt_en;
  end
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  sequence s_b_answer;
    !BVALID ##1 BVALID;
  endsequence
  sequence s_rd_taken;
    ARVALID && ARREADY;
  endsequence
  AST_B_LAT: assert property (wr_both |=> s_b_answer)
    else $error("write response not two cycles after request");
  AST_B_HOLD: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  AST_W_BLOCK: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write accepted while response pending");
  AST_R_LAT: assert property (s_rd_taken |=> RVALID)
    else $error("read data late");
  AST_R_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped early");
  AST_R_SLVERR: assert property ((s_rd_taken and ARADDR > OFS_RXD) |=>
                                 RRESP == RESP_SLVERR)
    else $error("unmapped read not refused");
  AST_B_SLVERR: assert property (wr_both && AWADDR > OFS_RXD |=>
                                 ##1 BRESP == RESP_SLVERR)
    else $error("unmapped write not refused");
  AST_DIS_QUIET: assert property (
    !en_ff && !$past(en_ff, 4) |-> !SDA_OE && !SCL_OE)
    else $error("line pulled while disabled");
  AST_OPEN_DRAIN: assert property (SCL_OUT == 1'b0 && SDA_OUT == 1'b0)
    else $error("line driven high");
endmodule : mmb_chk

bind mmb_top mmb_chk u_mmb_chk (
  .REF_CLK(REF_CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
  .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
  .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
  .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .SCL_OUT(SCL_OUT),
  .SCL_OE(SCL_OE), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE));

// >>> verification/mmb_far_master.sv
// Behavioural far-side master on the two-wire bus, 400 ns bit time
module mmb_far_master (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe,
  output logic      sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 100;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  task automatic start_cond();
    #13;
    sda_oe = 1'b1;
    #(2 * Q);
    scl_oe = 1'b1;
  endtask : start_cond
  task automatic stop_cond();
    #Q;
    sda_oe = 1'b1;
    #Q;
    scl_oe = 1'b0;
    #(2 * Q);
    sda_oe = 1'b0;
    #(2 * Q);
  endtask : stop_cond
  task automatic bit_out(input logic b);
    #Q;
    sda_oe = ~b;
    #Q;
    scl_oe = 1'b0;
    #(2 * Q);
    scl_oe = 1'b1;
  endtask : bit_out
  // Sampled at the end of the high phase, clear of the device's lag
  task automatic bit_in(output logic b);
    #Q;
    sda_oe = 1'b0;
    #Q;
    scl_oe = 1'b0;
    #(2 * Q - 1);
    b = sda;
    #1;
    scl_oe = 1'b1;
  endtask : bit_in
  task automatic put_byte(input logic [7:0] v, output logic ak);
    for (int i = 7; i >= 0; i--)
      bit_out(v[i]);
    bit_in(ak);
  endtask : put_byte
  task automatic get_byte(input logic ak, output logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      bit_in(v[i]);
    bit_out(ak);
  endtask : get_byte
endmodule : mmb_far_master

// >>> verification/tb_top.sv
// Self-checking bench: register tasks and far-side master traffic
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mmb_pkg::*;
  logic       REF_CLK = 1'b0;
  logic       RST = 1'b1;
  mmb_addr_t  AWADDR = 8'h00, ARADDR = 8'h00;
  mmb_word_t  WDATA = 32'h0, RDATA;
  logic [3:0] WSTRB = 4'hF;
  logic       AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic       ARVALID = 1'b0, RREADY = 1'b0;
  logic       AWREADY, WREADY, BVALID, ARREADY, RVALID;
  mmb_resp_t  BRESP, RRESP, bresp_seen;
  logic       SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, far_scl_oe, far_sda_oe;
  wire logic  scl_w, sda_w;
  int         fails = 0;
  int         checks_done = 0;
  always #25 REF_CLK = ~REF_CLK;
  // Pull-ups: a released line reads high
  assign scl_w = ~((SCL_OE & ~SCL_OUT) | far_scl_oe);
  assign sda_w = ~((SDA_OE & ~SDA_OUT) | far_sda_oe);
  mmb_top u_mmb_top (
    .REF_CLK(REF_CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .SCL_IN(scl_w),
    .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_IN(sda_w), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE));
  mmb_far_master u_far (.scl(scl_w), .sda(sda_w), .scl_oe(far_scl_oe),
                        .sda_oe(far_sda_oe));
  task automatic chk(input string what, input mmb_word_t e,
                     input mmb_word_t g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // Waits for the answer; only the watchdog ends a hang
  task automatic wr(input mmb_addr_t a, input mmb_word_t d);
    @(posedge REF_CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge REF_CLK);
      if (AWVALID && AWREADY)
        AWVALID <= 1'b0;
      if (WVALID && WREADY)
        WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    bresp_seen = BRESP;
    BREADY <= 1'b0;
  endtask : wr
  task automatic rd(input mmb_addr_t a, output mmb_word_t d,
                    output mmb_resp_t r);
    @(posedge REF_CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge REF_CLK);
      if (ARVALID && ARREADY)
        ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask : rd
  task automatic rchk(input string what, input mmb_addr_t a,
                      input mmb_word_t m, input mmb_word_t e);
    mmb_word_t d;
    mmb_resp_t r;
    rd(a, d, r);
    chk(what, e, d & m);
  endtask : rchk
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // host time-out on a hung bus
  initial begin
    #3ms;
    fails++;
    test_done();
  end
  initial begin
    mmb_word_t  d;
    mmb_resp_t  r;
    logic       ak;
    logic [7:0] b;
    int         n;
    repeat (6) @(posedge REF_CLK);
    RST <= 1'b0;
    rchk("stat", OFS_STAT, 32'h3FF, 32'h00A);
    rchk("txd", OFS_TXD, 32'hFF, 32'hFF);
    rchk("addr", OFS_ADDR, 32'hFF, 32'hA0);
    rd(8'h14, d, r);
    chk("rresp", 32'(RESP_SLVERR), 32'(r));
    wr(8'h14, 32'h0);
    chk("bresp", 32'(RESP_SLVERR), 32'(bresp_seen));
    wr(OFS_RXD, 32'h55);
    chk("bresp ok", 32'(RESP_OKAY), 32'(bresp_seen));
    rchk("rxd", OFS_RXD, 32'hFF, 32'h00);
    WSTRB <= 4'h0;
    wr(OFS_TXD, 32'h12);
    WSTRB <= 4'hF;
    rchk("txd strobe", OFS_TXD, 32'hFF, 32'hFF);
    $display("test reset done");
    wr(OFS_CTRL, 32'h80);
    wr(OFS_TXD, 32'h96);
    rchk("txbe clr", OFS_STAT, 32'h2, 32'h0);
    u_far.start_cond();
    u_far.put_byte(8'hA1, ak);
    chk("rd addr ack", 32'h0, 32'(ak));
    rchk("rxd addr", OFS_RXD, 32'hFF, 32'hA1);
    rchk("stat match", OFS_STAT, 32'hF6, 32'hF6);
    wr(OFS_TXD, 32'h3C);
    u_far.get_byte(1'b0, b);
    chk("byte0", 32'h96, 32'(b));
    rchk("txbe next", OFS_STAT, 32'h2, 32'h2);
    wr(OFS_TXD, 32'hC5);
    u_far.get_byte(1'b1, b);
    chk("byte1", 32'h3C, 32'(b));
    rchk("nack", OFS_STAT, 32'hA, 32'h8);
    rchk("txd kept", OFS_TXD, 32'hFF, 32'hC5);
    chk("sda free", 32'h1, 32'(sda_w));
    u_far.stop_cond();
    rchk("idle", OFS_STAT, 32'h4, 32'h0);
    $display("test slave transmit done");
    u_far.start_cond();
    u_far.put_byte(8'hA0, ak);
    chk("wr addr ack", 32'h0, 32'(ak));
    rchk("rxd waddr", OFS_RXD, 32'hFF, 32'hA0);
    u_far.put_byte(8'h5A, ak);
    chk("data ack", 32'h0, 32'(ak));
    u_far.put_byte(8'h77, ak);
    rchk("full", OFS_STAT, 32'h81, 32'h81);
    rchk("rxd data", OFS_RXD, 32'hFF, 32'h5A);
    rchk("rxbf clr", OFS_STAT, 32'h1, 32'h0);
    wr(OFS_STAT, 32'h0);
    u_far.put_byte(8'h3D, ak);
    rchk("rxif", OFS_STAT, 32'h81, 32'h81);
    rchk("rxd next", OFS_RXD, 32'hFF, 32'h3D);
    u_far.stop_cond();
    $display("test slave receive done");
    u_far.start_cond();
    u_far.put_byte(8'hB0, ak);
    chk("no match", 32'h1, 32'(ak));
    rchk("hung", OFS_STAT, 32'h4, 32'h4);
    wr(OFS_CTRL, 32'h90);
    rchk("lost", OFS_STAT, 32'h204, 32'h204);
    rchk("start dropped", OFS_CTRL, 32'h10, 32'h0);
    wr(OFS_CTRL, 32'h0);
    rchk("busy clr", OFS_STAT, 32'h4, 32'h0);
    wr(OFS_STAT, 32'h0);
    rchk("lost clr", OFS_STAT, 32'h200, 32'h0);
    u_far.stop_cond();
    u_far.start_cond();
    u_far.put_byte(8'hA1, ak);
    chk("disabled", 32'h1, 32'(ak));
    u_far.stop_cond();
    wr(OFS_CTRL, 32'h80);
    u_far.start_cond();
    u_far.put_byte(8'hA0, ak);
    chk("resumed", 32'h0, 32'(ak));
    u_far.stop_cond();
    $display("test hang recovery done");
    wr(OFS_ADDR, 32'h42);
    wr(OFS_TXD, 32'h11);
    wr(OFS_CTRL, 32'h90);
    n = 0;
    do begin
      rd(OFS_STAT, d, r);
      n++;
    end while ((d & 32'h104) !== 32'h100 && n < 2000);
    chk("master nak", 32'h100, d & 32'h106);
    rchk("master off", OFS_CTRL, 32'h10, 32'h0);
    $display("test master nack done");
    test_done();
  end
endmodule : tb_top
